// ===== design/uart_channel_command_status.sv
module uart_channel_command_status (
    input  wire logic                                   ref_clk,
    input  wire logic                                   arst_n,
    input  wire logic [uart_ccs_pkg::ADDR_W-1:0]        address,
    input  wire logic                                   read,
    input  wire logic                                   write,
    input  wire logic [31:0]                            writedata,
    input  wire logic [3:0]                             byteenable,
    output logic      [31:0]                            readdata,
    output logic                                        waitrequest,
    input  wire uart_ccs_pkg::rx_in_s [1:0]             rx_in,
    input  wire logic [1:0]                             transmitter_ready,
    input  wire logic [1:0]                             transmitter_empty,
    output logic      [1:0]                             tx_load,
    output logic      [15:0]                            tx_char,
    input  wire logic                                   counter_timer_out,
    input  wire logic                                   tx_clock_chan_a,
    input  wire logic                                   rx_clock_chan_a,
    output logic      [7:0]                             out_pin
);
    import uart_ccs_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] cmd_index(input int c);
        return (c == 1) ? IDX_CMD_B : IDX_CMD_A;
    endfunction : cmd_index

    function automatic logic [4:0] data_index(input int c);
        return (c == 1) ? IDX_DATA_B : IDX_DATA_A;
    endfunction : data_index

    state_s          s_q;
    state_s          s_d;
    logic            req;
    logic            do_write;
    logic            do_read;
    logic [4:0]      idx;
    logic [7:0]      wb;
    rx_char_s [1:0]  head;
    logic [1:0]      not_empty;
    logic [1:0]      fifo_full;
    logic [1:0]      tx_rdy;
    logic [2:0]      err_view [2];
    logic [7:0]      status [2];
    logic [1:0]      wr_cmd;
    logic [1:0]      push;
    logic [1:0]      pop;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign req         = read | write;
    assign do_write    = write & s_q.ack & byteenable[0];
    assign do_read     = read & s_q.ack;
    assign idx         = address[ADDR_W-1:2];
    assign wb          = writedata[7:0];
    assign waitrequest = req & ~s_q.ack;
    assign readdata    = s_q.rdata;

    // ----------------------------------------------------------------
    // channel views
    // ----------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            head[c]      = s_q.ch[c].fifo[s_q.ch[c].rd_ptr];
            not_empty[c] = (s_q.ch[c].count != '0);
            fifo_full[c] = (s_q.ch[c].count == (PTR_W+1)'(FIFO_DEPTH));
            tx_rdy[c]    = transmitter_ready[c] & s_q.ch[c].tx_en;
            // block mode shows accumulated flags, character mode the head's
            if (s_q.blk_mode[c]) begin
                err_view[c] = s_q.ch[c].blk_err;
            end else begin
                err_view[c] = not_empty[c] ? {head[c].brk, head[c].frm, head[c].par} : 3'h0;
            end
            status[c]    = {err_view[c], s_q.ch[c].overrun, transmitter_empty[c],
                            tx_rdy[c], fifo_full[c], not_empty[c]};
            wr_cmd[c]    = do_write && (idx == cmd_index(c));
            pop[c]       = do_read && (idx == data_index(c)) && not_empty[c];
            push[c]      = rx_in[c].valid && s_q.ch[c].rx_en && !fifo_full[c];
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d     = s_q;
        s_d.ack = req & ~s_q.ack;
        for (int c = 0; c < CHANNELS; c++) begin
            s_d.ch[c].tx_load = 1'b0;
            if (wr_cmd[c]) begin
                if (wb[CMD_RX_EN]) begin
                    s_d.ch[c].rx_en = 1'b1;
                end
                if (wb[CMD_RX_DIS]) begin
                    s_d.ch[c].rx_en = 1'b0;
                end
                if (wb[CMD_TX_EN]) begin
                    s_d.ch[c].tx_en = 1'b1;
                end
                if (wb[CMD_TX_DIS]) begin
                    s_d.ch[c].tx_en = 1'b0;
                end
                if (wb[7:MISC_LSB] == MISC_RST_ERR) begin
                    s_d.ch[c].blk_err = 3'h0;
                    s_d.ch[c].overrun = 1'b0;
                    for (int e = 0; e < FIFO_DEPTH; e++) begin
                        s_d.ch[c].fifo[e].brk = 1'b0;
                        s_d.ch[c].fifo[e].frm = 1'b0;
                        s_d.ch[c].fifo[e].par = 1'b0;
                    end
                end
                if (wb[7:MISC_LSB] == MISC_RST_RX) begin
                    s_d.ch[c].rx_en   = 1'b0;
                    s_d.ch[c].blk_err = 3'h0;
                    s_d.ch[c].overrun = 1'b0;
                    s_d.ch[c].wr_ptr  = '0;
                    s_d.ch[c].rd_ptr  = '0;
                    s_d.ch[c].count   = '0;
                end
            end
            // in character mode a character read retires its flags with it
            if (pop[c]) begin
                s_d.ch[c].rd_ptr = PTR_W'(s_d.ch[c].rd_ptr + 1'b1);
                s_d.ch[c].count  = (PTR_W+1)'(s_d.ch[c].count - 1'b1);
            end
            // arrivals after the clears so a new flag is never lost
            if (push[c]) begin
                s_d.ch[c].fifo[s_d.ch[c].wr_ptr] = rx_in[c].ch;
                s_d.ch[c].wr_ptr  = PTR_W'(s_d.ch[c].wr_ptr + 1'b1);
                s_d.ch[c].count   = (PTR_W+1)'(s_d.ch[c].count + 1'b1);
                s_d.ch[c].blk_err = s_d.ch[c].blk_err
                                  | {rx_in[c].ch.brk, rx_in[c].ch.frm, rx_in[c].ch.par};
            end
            if (rx_in[c].valid && s_q.ch[c].rx_en && fifo_full[c] && !pop[c]) begin
                s_d.ch[c].overrun = 1'b1;
            end
            if (do_write && (idx == data_index(c)) && tx_rdy[c]) begin
                s_d.ch[c].tx_load = 1'b1;
                s_d.ch[c].tx_char = wb;
            end
        end
        if (do_write && (idx == IDX_OUT_CFG)) begin
            s_d.out_cfg = wb;
        end
        if (do_write && (idx == IDX_OUT_SET)) begin
            s_d.out_latch = s_q.out_latch | wb;
        end
        if (do_write && (idx == IDX_ERR_MODE)) begin
            s_d.blk_mode = wb[1:0];
        end
        if (req && !s_q.ack) begin
            unique case (idx)
                IDX_CMD_A:    s_d.rdata = {24'h000000, status[0]};
                IDX_CMD_B:    s_d.rdata = {24'h000000, status[1]};
                IDX_DATA_A:   s_d.rdata = {24'h000000, head[0].data};
                IDX_DATA_B:   s_d.rdata = {24'h000000, head[1].data};
                IDX_ERR_MODE: s_d.rdata = {30'h00000000, s_q.blk_mode};
                default:      s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q           <= '0;
            s_q.out_cfg   <= OUT_CFG_RST;
            s_q.out_latch <= LATCH_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic [1:0] pin3_sel;
    logic       pin3_src;

    assign pin3_sel = s_q.out_cfg[CFG_PIN3_LSB +: 2];

    always_comb begin
        unique case (pin3_sel)
            PIN3_LATCH: pin3_src = ~s_q.out_latch[3];
            PIN3_TIMER: pin3_src = counter_timer_out;
            PIN3_TXCLK: pin3_src = tx_clock_chan_a;
            PIN3_RXCLK: pin3_src = rx_clock_chan_a;
        endcase
    end

    assign out_pin[7]   = s_q.out_cfg[CFG_PIN7] ? tx_rdy[1] : ~s_q.out_latch[7];
    assign out_pin[6]   = s_q.out_cfg[CFG_PIN6] ? tx_rdy[0] : ~s_q.out_latch[6];
    assign out_pin[5]   = s_q.out_cfg[CFG_PIN5] ? not_empty[1] : ~s_q.out_latch[5];
    assign out_pin[4]   = s_q.out_cfg[CFG_PIN4] ? not_empty[0] : ~s_q.out_latch[4];
    assign out_pin[3]   = pin3_src;
    assign out_pin[2:0] = ~s_q.out_latch[2:0];
    assign tx_load      = {s_q.ch[1].tx_load, s_q.ch[0].tx_load};
    assign tx_char      = {s_q.ch[1].tx_char, s_q.ch[0].tx_char};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_RX_ENABLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_cmd[0] && wb[CMD_RX_EN] && !wb[CMD_RX_DIS] && (wb[7:MISC_LSB] != MISC_RST_RX)
        |=> s_q.ch[0].rx_en)
        else $error("receiver enable not applied");

    AST_DISABLE_WINS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_cmd[0] && wb[CMD_TX_EN] && wb[CMD_TX_DIS] |=> !s_q.ch[0].tx_en)
        else $error("disable did not win");

    AST_TX_REFUSED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        do_write && (idx == IDX_DATA_A) && !s_q.ch[0].tx_en |=> !tx_load[0])
        else $error("disabled transmitter loaded");

    AST_STATUS_LIVE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req && !s_q.ack && (idx == IDX_CMD_A)
        |=> (readdata[3] == $past(transmitter_empty[0])) && (readdata[2] == $past(tx_rdy[0]))
            && (readdata[1] == $past(fifo_full[0])) && (readdata[0] == $past(not_empty[0])))
        else $error("status low bits wrong");

    AST_HEAD_FLAGS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req && !s_q.ack && (idx == IDX_CMD_A) && !s_q.blk_mode[0] && not_empty[0]
        |=> (readdata[7] == $past(head[0].brk)) && (readdata[6] == $past(head[0].frm))
            && (readdata[5] == $past(head[0].par)))
        else $error("status flags not from head");

    AST_CHAR_DROP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pop[0] && !s_q.blk_mode[0] && (s_q.ch[0].count == 4'h1) && !push[0]
        |=> err_view[0] == 3'h0)
        else $error("flags kept after read");

    AST_BLOCK_KEEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.blk_mode[0] && !wr_cmd[0] |=> (s_q.ch[0].blk_err & $past(s_q.ch[0].blk_err))
                                         == $past(s_q.ch[0].blk_err))
        else $error("block error flags lost");

    AST_ERR_RESET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_cmd[0] && (wb[7:MISC_LSB] == MISC_RST_ERR) && !push[0] |=> s_q.ch[0].blk_err == 3'h0)
        else $error("error reset ignored");

    AST_BIT_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        do_write && (idx == IDX_OUT_SET) |=> s_q.out_latch == ($past(s_q.out_latch) | $past(wb)))
        else $error("bit set wrong");

    AST_PIN_INV: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !s_q.out_cfg[CFG_PIN7] |-> out_pin[7] == !s_q.out_latch[7])
        else $error("pin not inverted");

    AST_PIN6_TRANSMITTER_READY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.out_cfg[CFG_PIN6] |-> out_pin[6] == (transmitter_ready[0] && s_q.ch[0].tx_en))
        else $error("pin 6 source wrong");

    AST_PIN3_TIMER: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pin3_sel == PIN3_TIMER |-> out_pin[3] == counter_timer_out)
        else $error("pin 3 source wrong");

    AST_PIN3_LATCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pin3_sel == PIN3_LATCH |-> out_pin[3] == !s_q.out_latch[3])
        else $error("pin 3 latch source wrong");

    AST_PIN7_TRANSMITTER_READY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.out_cfg[CFG_PIN7] |-> out_pin[7] == (transmitter_ready[1] && s_q.ch[1].tx_en))
        else $error("pin 7 source wrong");

    AST_PIN5_RECEIVER_READY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.out_cfg[CFG_PIN5] |-> out_pin[5] == (s_q.ch[1].count != 4'h0))
        else $error("pin 5 source wrong");

    AST_PIN4_RECEIVER_READY: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.out_cfg[CFG_PIN4] |-> out_pin[4] == (s_q.ch[0].count != 4'h0))
        else $error("pin 4 source wrong");

    AST_TX_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        do_write && (idx == IDX_DATA_A) && transmitter_ready[0] && s_q.ch[0].tx_en
        |=> tx_load[0] && (tx_char[7:0] == $past(wb)))
        else $error("enabled transmitter not loaded");

    AST_PUSH_FLAGS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rx_in[0].valid && s_q.ch[0].rx_en && (s_q.ch[0].count != 4'h8) && !wr_cmd[0]
        |=> s_q.ch[0].fifo[$past(s_q.ch[0].wr_ptr)] == $past(rx_in[0].ch))
        else $error("character flags not stored");

    AST_OVERRUN_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rx_in[0].valid && s_q.ch[0].rx_en && (s_q.ch[0].count == 4'h8) && !pop[0]
        |=> s_q.ch[0].overrun)
        else $error("overrun not flagged");

    AST_RX_REFUSED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rx_in[0].valid && !s_q.ch[0].rx_en && !wr_cmd[0] && !pop[0]
        |=> s_q.ch[0].count == $past(s_q.ch[0].count))
        else $error("disabled receiver stored a character");

    AST_RX_DISABLE_WINS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_cmd[1] && wb[CMD_RX_EN] && wb[CMD_RX_DIS] |=> !s_q.ch[1].rx_en)
        else $error("receiver disable did not win");
endmodule : uart_channel_command_status

// ===== shared/uart_ccs_pkg.sv
package uart_ccs_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int CHANNELS   = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W      = 3;
    localparam int ADDR_W     = 7;
    // ----------------------------------------------------------------
    // register indexes (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [4:0] IDX_CMD_A    = 5'h01;
    localparam logic [4:0] IDX_DATA_A   = 5'h03;
    localparam logic [4:0] IDX_CMD_B    = 5'h09;
    localparam logic [4:0] IDX_DATA_B   = 5'h0B;
    localparam logic [4:0] IDX_OUT_CFG  = 5'h0D;
    localparam logic [4:0] IDX_OUT_SET  = 5'h0E;
    localparam logic [4:0] IDX_ERR_MODE = 5'h10;
    // ----------------------------------------------------------------
    // command fields and codes
    // ----------------------------------------------------------------
    localparam int         CMD_RX_EN   = 0;
    localparam int         CMD_RX_DIS  = 1;
    localparam int         CMD_TX_EN   = 2;
    localparam int         CMD_TX_DIS  = 3;
    localparam int         MISC_LSB    = 4;
    localparam logic [3:0] MISC_RST_ERR = 4'h4;
    localparam logic [3:0] MISC_RST_RX  = 4'h2;
    // ----------------------------------------------------------------
    // output configuration fields and reset values
    // ----------------------------------------------------------------
    localparam int         CFG_PIN7    = 7;
    localparam int         CFG_PIN6    = 6;
    localparam int         CFG_PIN5    = 5;
    localparam int         CFG_PIN4    = 4;
    localparam int         CFG_PIN3_LSB = 2;
    localparam logic [1:0] PIN3_LATCH  = 2'h0;
    localparam logic [1:0] PIN3_TIMER  = 2'h1;
    localparam logic [1:0] PIN3_TXCLK  = 2'h2;
    localparam logic [1:0] PIN3_RXCLK  = 2'h3;
    localparam logic [7:0] OUT_CFG_RST = 8'h00;
    localparam logic [7:0] LATCH_RST   = 8'h00;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } rx_char_s;

    typedef struct packed {
        logic     valid;
        rx_char_s ch;
    } rx_in_s;

    typedef struct packed {
        logic                          rx_en;
        logic                          tx_en;
        rx_char_s [FIFO_DEPTH-1:0]     fifo;
        logic     [PTR_W-1:0]          wr_ptr;
        logic     [PTR_W-1:0]          rd_ptr;
        logic     [PTR_W:0]            count;
        logic     [2:0]                blk_err;
        logic                          overrun;
        logic                          tx_load;
        logic     [7:0]                tx_char;
    } chan_s;

    typedef struct packed {
        chan_s [CHANNELS-1:0] ch;
        logic  [7:0]          out_cfg;
        logic  [7:0]          out_latch;
        logic  [1:0]          blk_mode;
        logic                 ack;
        logic  [31:0]         rdata;
    } state_s;
endpackage : uart_ccs_pkg

// ===== test/line_side_model.sv
module line_side_model (
    input  wire logic                     ref_clk,
    input  wire logic [1:0]               stall,
    input  wire logic [1:0]               tx_load,
    input  wire logic [15:0]              tx_char,
    output uart_ccs_pkg::rx_in_s [1:0]    rx_in,
    output logic      [1:0]               transmitter_ready,
    output logic      [1:0]               transmitter_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    import uart_ccs_pkg::*;
    // ----------------------------------------------------------------
    // transmitter side: stall makes it slow
    // ----------------------------------------------------------------
    int         n_load = 0;
    logic [7:0] last_a = 8'h00;
    assign transmitter_ready = ~stall;
    assign transmitter_empty = ~stall;
    always @(posedge ref_clk) begin
        if (tx_load[0]) begin
            n_load <= n_load + 1;
            last_a <= tx_char[7:0];
        end
    end
    // ----------------------------------------------------------------
    // receiver side: one pulse per character, lines scrambled after
    // ----------------------------------------------------------------
    initial begin
        rx_in = '0;
    end
    task automatic send(input int c, input logic [2:0] f, input logic [7:0] d);
        rx_in[c] <= {1'b1, f, d};
        @(posedge ref_clk);
        rx_in[c] <= {1'b0, ~f, ~d};
        @(posedge ref_clk);
    endtask : send
endmodule : line_side_model

// ===== test/uart_channel_command_status_tb.sv
module uart_channel_command_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_ccs_pkg::*;
    logic         ref_clk;
    logic         arst_n;
    logic [6:0]   address;
    logic         read;
    logic         write;
    logic [31:0]  writedata;
    logic [31:0]  readdata;
    logic         waitrequest;
    logic [1:0]   stall;
    logic [1:0]   tx_load;
    logic [15:0]  tx_char;
    logic [7:0]   out_pin;
    logic         ct_out;
    logic         txclk_a;
    logic         rxclk_a;
    rx_in_s [1:0] rx_in;
    logic [1:0]   transmitter_ready;
    logic [1:0]   transmitter_empty;
    logic [31:0]  q;
    int           n_errors;
    int           total_checks;

    uart_channel_command_status dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .rx_in(rx_in), .transmitter_ready(transmitter_ready), .transmitter_empty(transmitter_empty),
        .tx_load(tx_load), .tx_char(tx_char), .counter_timer_out(ct_out),
        .tx_clock_chan_a(txclk_a), .rx_clock_chan_a(rxclk_a), .out_pin(out_pin));

    line_side_model far (
        .ref_clk(ref_clk), .stall(stall), .tx_load(tx_load), .tx_char(tx_char), .rx_in(rx_in),
        .transmitter_ready(transmitter_ready), .transmitter_empty(transmitter_empty));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        write <= wr;
        read <= ~wr;
        address <= {idx, 2'h0};
        writedata <= {24'h0, d};
        // waitrequest and readdata are read at the edge, before it updates them
        @(posedge ref_clk);
        while (waitrequest && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest) begin
            n_errors++;
            test_done();
        end
        @(posedge ref_clk);
    endtask : bus

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 8'h00, q);
        chk(q, e);
    endtask : rd

    task automatic pin(input logic [7:0] e);
        @(negedge ref_clk);
        chk({24'h0, out_pin}, {24'h0, e});
        @(posedge ref_clk);
    endtask : pin

    task automatic loads(input int n, input logic [7:0] c);
        @(negedge ref_clk);
        chk(32'(far.n_load), 32'(n));
        chk({24'h0, far.last_a}, {24'h0, c});
        @(posedge ref_clk);
    endtask : loads
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_pins();
        logic [3:0] p3 = 4'b0101;
        pin(8'hFF);
        wr(IDX_OUT_SET, 8'h81);
        wr(IDX_OUT_SET, 8'h02);
        pin(8'h7C);
        rd(5'h1F, 32'h0);
        wr(5'h1F, 8'hFF);
        pin(8'h7C);
        wr(IDX_CMD_A, 8'h04);
        wr(IDX_CMD_B, 8'h05);
        far.send(1, 3'h0, 8'h11);
        wr(IDX_OUT_CFG, 8'hF0);
        pin(8'hEC);
        stall <= 2'b10;
        pin(8'h6C);
        stall <= 2'b01;
        pin(8'hAC);
        stall <= 2'b00;
        rd(IDX_CMD_B, 32'h0D);
        rd(IDX_DATA_B, 32'h11);
        pin(8'hCC);
        wr(IDX_CMD_B, 8'h03);
        far.send(1, 3'h0, 8'h12);
        rd(IDX_CMD_B, 32'h0C);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_OUT_CFG, {4'h0, 2'(c), 2'h0});
            pin(8'h74 | {4'h0, p3[c], 3'h0});
        end
    endtask : t_pins

    task automatic t_tx();
        wr(IDX_CMD_A, 8'h08);
        wr(IDX_DATA_A, 8'h33);
        loads(0, 8'h00);
        rd(IDX_CMD_A, 32'h08);
        wr(IDX_CMD_A, 8'h04);
        rd(IDX_CMD_A, 32'h0C);
        wr(IDX_DATA_A, 8'h5A);
        loads(1, 8'h5A);
        wr(IDX_CMD_A, 8'h0C);
        rd(IDX_CMD_A, 32'h08);
        wr(IDX_DATA_A, 8'hA5);
        loads(1, 8'h5A);
    endtask : t_tx

    task automatic t_rx();
        far.send(0, 3'h4, 8'h40);
        rd(IDX_CMD_A, 32'h08);
        wr(IDX_CMD_A, 8'h01);
        far.send(0, 3'h4, 8'h41);
        far.send(0, 3'h1, 8'h42);
        rd(IDX_CMD_A, 32'h89);
        rd(IDX_DATA_A, 32'h41);
        rd(IDX_CMD_A, 32'h29);
        rd(IDX_DATA_A, 32'h42);
        rd(IDX_CMD_A, 32'h08);
    endtask : t_rx

    task automatic t_full();
        for (int i = 0; i < 9; i++) begin
            far.send(0, 3'h0, 8'(i));
        end
        rd(IDX_CMD_A, 32'h1B);
        wr(IDX_CMD_A, 8'h40);
        rd(IDX_CMD_A, 32'h0B);
        wr(IDX_CMD_A, 8'h20);
        rd(IDX_CMD_A, 32'h08);
        far.send(0, 3'h0, 8'h77);
        rd(IDX_CMD_A, 32'h08);
    endtask : t_full

    task automatic t_err();
        wr(IDX_CMD_A, 8'h01);
        far.send(0, 3'h2, 8'h51);
        rd(IDX_CMD_A, 32'h49);
        wr(IDX_CMD_A, 8'h40);
        rd(IDX_CMD_A, 32'h09);
        rd(IDX_DATA_A, 32'h51);
        wr(IDX_ERR_MODE, 8'h01);
        rd(IDX_ERR_MODE, 32'h01);
        far.send(0, 3'h1, 8'h52);
        rd(IDX_DATA_A, 32'h52);
        rd(IDX_CMD_A, 32'h28);
        wr(IDX_CMD_A, 8'h40);
        rd(IDX_CMD_A, 32'h08);
    endtask : t_err
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 7'h00;
        writedata = 32'h0;
        stall = 2'b00;
        ct_out = 1'b0;
        txclk_a = 1'b1;
        rxclk_a = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_pins();
        t_tx();
        t_rx();
        t_full();
        t_err();
        test_done();
    end
endmodule : uart_channel_command_status_tb
